// ### field_signal_trim_path.sv
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module field_signal_trim_path
    import fstp_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               srst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               sampleValid,
    input  wire logic signed [15:0] sampleIn,
    input  wire logic signed [8:0]  ambientTemp,
    output logic                    outValid,
    output logic [11:0]             outCode,
    output logic                    curveValid,
    output logic signed [12:0]      curveOut
);
    logic [31:0]        gainReg_ff, tc1Reg_ff, tc2Reg_ff, ofsReg_ff, tcoReg_ff, clampReg_ff, postReg_ff;
    logic [31:0]        prdata_ff;
    logic               pready_ff, pslverr_ff;
    fstp_stage_t        stage_ff;
    logic               s1Valid_ff, s2Valid_ff, outValid_ff, curveValid_ff;
    logic signed [8:0]  dt1_ff;
    logic               warm1_ff;
    logic signed [15:0] smp1_ff;
    logic signed [8:0]  dt2_ff;
    logic               warm2_ff;
    logic [11:0]        outCode_ff;
    logic signed [12:0] curveOut_ff;
    logic signed [8:0]  nxt_dt;
    logic               nxt_warm;
    fstp_gain_t         gainCfg;
    logic signed [47:0] prod;
    logic signed [16:0] nxt_gain;
    logic signed [31:0] ofsSum;
    logic signed [12:0] nxt_ofs;
    logic signed [31:0] poly;

    function automatic logic signed [31:0] sx(input logic [15:0] v, input int w);
        logic [31:0] u;
        u = {v, 16'h0000} << (16 - w);
        return signed'(u) >>> (32 - w);
    endfunction

    function automatic logic signed [16:0] sat17(input logic signed [47:0] v);
        if (v > 48'sd65535) return 17'sd65535;
        else if (v < -48'sd65536) return -17'sd65536;
        else return v[16:0];
    endfunction

    function automatic logic signed [12:0] sat13(input logic signed [31:0] v);
        if (v > 32'sd4095) return 13'sd4095;
        else if (v < -32'sd4096) return -13'sd4096;
        else return v[12:0];
    endfunction

    // APB slave, one wait state
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else
        begin
            pready_ff  <= psel && penable && !pready_ff;
            pslverr_ff <= 1'b0;
            if (psel && penable && !pready_ff)
            begin
                prdata_ff <= 32'h0000_0000;
                if (paddr == FSTP_GAIN_OFS) prdata_ff <= gainReg_ff;
                else if (paddr == FSTP_TCGAIN1_OFS) prdata_ff <= tc1Reg_ff;
                else if (paddr == FSTP_TCGAIN2_OFS) prdata_ff <= tc2Reg_ff;
                else if (paddr == FSTP_OFFSET_OFS) prdata_ff <= ofsReg_ff;
                else if (paddr == FSTP_TCOFS_OFS) prdata_ff <= tcoReg_ff;
                else if (paddr == FSTP_CLAMP_OFS) prdata_ff <= clampReg_ff;
                else if (paddr == FSTP_POST_OFS) prdata_ff <= postReg_ff;
                else if (paddr == FSTP_STATUS_OFS) prdata_ff <= {19'h0_0000, stage_ff.ofsOut};
                else pslverr_ff <= 1'b1;
            end
        end
    end

    // Register writes, field widths masked
    // field widths
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            gainReg_ff  <= FSTP_GAIN_RST;
            tc1Reg_ff   <= 32'h0000_0000;
            tc2Reg_ff   <= 32'h0000_0000;
            ofsReg_ff   <= 32'h0000_0000;
            tcoReg_ff   <= 32'h0000_0000;
            clampReg_ff <= FSTP_CLAMP_RST;
            postReg_ff  <= FSTP_POST_RST;
        end
        else if (psel && penable && pwrite && pready_ff)
        begin
            if (paddr == FSTP_GAIN_OFS) gainReg_ff <= pwdata & 32'h0000_F7FF;
            else if (paddr == FSTP_TCGAIN1_OFS) tc1Reg_ff <= pwdata & 32'h007F_F7FF;
            else if (paddr == FSTP_TCGAIN2_OFS) tc2Reg_ff <= pwdata & 32'h003F_F3FF;
            else if (paddr == FSTP_OFFSET_OFS) ofsReg_ff <= pwdata & 32'h0000_FFFF;
            else if (paddr == FSTP_TCOFS_OFS) tcoReg_ff <= pwdata & 32'h00FF_FFFF;
            else if (paddr == FSTP_CLAMP_OFS) clampReg_ff <= pwdata & 32'h00FF_FFFF;
            else if (paddr == FSTP_POST_OFS) postReg_ff <= pwdata & 32'h03FF_FFFF;
        end
    end

    assign nxt_dt = ambientTemp - FSTP_TREF;
    assign nxt_warm = (nxt_dt >= 9'sd0);

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s1Valid_ff <= 1'b0;
            dt1_ff     <= 9'sd0;
            warm1_ff   <= 1'b1;
            smp1_ff    <= 16'sd0;
        end
        else
        begin
            s1Valid_ff <= sampleValid;
            dt1_ff     <= nxt_dt;
            warm1_ff   <= nxt_warm;
            smp1_ff    <= sampleIn;
        end
    end

    assign gainCfg = fstp_gain_t'({gainReg_ff[FSTP_SIGN_POS], gainReg_ff[FSTP_COARSE_POS +: 3], gainReg_ff[10:0]});

    always_comb
    begin
        logic signed [31:0] c1, c2;
        c1 = 32'sd0;
        c2 = 32'sd0;
        if (warm1_ff)
        begin
            c1 = sx(16'(tc1Reg_ff[10:0]), 11) * FSTP_TC1_WARM_K;
            c2 = sx(16'(tc2Reg_ff[9:0]), 10) * FSTP_TC2_WARM_K;
        end
        else
        begin
            c1 = sx(16'(tc1Reg_ff[FSTP_HI_POS +: 11]), 11) * FSTP_TC1_COOL_K;
            c2 = sx(16'(tc2Reg_ff[FSTP_HI_POS +: 10]), 10) * FSTP_TC2_COOL_K;
        end
        poly = (32'sd1 <<< 20) + ((((c2 * 32'(dt1_ff)) >>> FSTP_TC2_SHIFT) + c1) * 32'(dt1_ff) <<< (20 - FSTP_TC_SHIFT));
    end

    // gain first: coarse 2^code (1..32 over 0..5), then fine
    always_comb
    begin
        logic signed [47:0] g;
        logic [2:0]         cs;
        cs = (gainCfg.coarse > 3'd5) ? 3'd5 : gainCfg.coarse;
        g = 48'(smp1_ff) <<< cs;
        g = (g * 48'(signed'({1'b0, gainCfg.fine}) + 48'sd1024)) >>> FSTP_FINE_SHIFT;
        g = (g * 48'(poly)) >>> 20;
        prod = gainCfg.sign ? -g : g;
    end
    assign nxt_gain = sat17(prod);

    always_comb
    begin
        logic signed [31:0] otc;
        otc = warm2_ff ? sx(16'(tcoReg_ff[11:0]), 12) : (sx(16'(tcoReg_ff[FSTP_HI_POS +: 12]), 12) <<< 1);
        ofsSum = 32'(stage_ff.gainOut) + sx(ofsReg_ff[15:0], 16) + ((otc * 32'(dt2_ff)) >>> FSTP_OTC_SHIFT);
    end
    assign nxt_ofs = sat13(ofsSum);

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            stage_ff   <= '0;
            s2Valid_ff <= 1'b0;
            dt2_ff     <= 9'sd0;
            warm2_ff   <= 1'b1;
        end
        else
        begin
            s2Valid_ff <= s1Valid_ff;
            dt2_ff     <= dt1_ff;
            warm2_ff   <= warm1_ff;
            if (s1Valid_ff) stage_ff.gainOut <= nxt_gain;
            if (s2Valid_ff) stage_ff.ofsOut <= nxt_ofs;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        logic [12:0]        code;
        logic signed [31:0] pc;
        if (srst)
        begin
            outValid_ff   <= 1'b0;
            outCode_ff    <= 12'h000;
            curveValid_ff <= 1'b0;
            curveOut_ff   <= 13'sd0;
        end
        else
        begin
            code = 13'(nxt_ofs + 13'sd2048);
            if (nxt_ofs < -13'sd2048) code = 13'd0;
            if (nxt_ofs > 13'sd2047) code = 13'd4095;
            if (code[11:0] < clampReg_ff[11:0]) code = {1'b0, clampReg_ff[11:0]};
            if (code[11:0] > clampReg_ff[FSTP_HI_POS +: 12]) code = {1'b0, clampReg_ff[FSTP_HI_POS +: 12]};
            outValid_ff <= s2Valid_ff;
            if (s2Valid_ff) outCode_ff <= code[11:0];
            pc = postReg_ff[FSTP_PSIGN_POS] ? -32'(nxt_ofs) : 32'(nxt_ofs);
            if (postReg_ff[FSTP_PSIGN_POS + 1]) pc = -pc;
            pc = (pc * sx(16'(postReg_ff[11:0]), 12)) >>> 11;
            pc = pc + sx(16'(postReg_ff[FSTP_HI_POS +: 12]), 12);
            curveValid_ff <= s2Valid_ff;
            if (s2Valid_ff) curveOut_ff <= sat13(pc);
        end
    end

    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;
    assign outValid   = outValid_ff;
    assign outCode    = outCode_ff;
    assign curveValid = curveValid_ff;
    assign curveOut   = curveOut_ff;

    AST_ZERO_WARM: assert property (@(posedge sys_clk) disable iff (srst)
        (ambientTemp == FSTP_TREF) |=> warm1_ff) else $error("zero delta not warm");
    AST_COOL: assert property (@(posedge sys_clk) disable iff (srst)
        (ambientTemp < FSTP_TREF) |=> !warm1_ff) else $error("cold not selected");
    AST_FLOOR: assert property (@(posedge sys_clk) disable iff (srst)
        (outValid && clampReg_ff[11:0] <= clampReg_ff[23:12]) |-> outCode >= $past(clampReg_ff[11:0]))
        else $error("below floor");
    AST_CEIL: assert property (@(posedge sys_clk) disable iff (srst)
        (outValid && $stable(clampReg_ff)) |-> outCode <= clampReg_ff[23:12]) else $error("above ceiling");
    AST_LAT: assert property (@(posedge sys_clk) disable iff (srst)
        sampleValid |-> ##3 outValid) else $error("latency wrong");
    AST_SAT17: assert property (@(posedge sys_clk) disable iff (srst)
        (s1Valid_ff && prod > 48'sd65535) |=> stage_ff.gainOut == 17'sd65535) else $error("gain wrapped");
    AST_SAT13: assert property (@(posedge sys_clk) disable iff (srst)
        (s2Valid_ff && ofsSum < -32'sd4096) |=> stage_ff.ofsOut == -13'sd4096) else $error("offset wrapped");
    AST_DT: assert property (@(posedge sys_clk) disable iff (srst)
        1'b1 |=> dt1_ff == $past(ambientTemp) - FSTP_TREF) else $error("delta wrong");
    AST_READY: assert property (@(posedge sys_clk) disable iff (srst)
        (psel && penable && !pready) |=> pready) else $error("no ready");
endmodule // field_signal_trim_path
`default_nettype wire

// ### fstp_pkg.sv
package fstp_pkg;
    // APB byte offsets
    localparam logic [11:0] FSTP_GAIN_OFS    = 12'h000;
    localparam logic [11:0] FSTP_TCGAIN1_OFS = 12'h004;
    localparam logic [11:0] FSTP_TCGAIN2_OFS = 12'h008;
    localparam logic [11:0] FSTP_OFFSET_OFS  = 12'h00C;
    localparam logic [11:0] FSTP_TCOFS_OFS   = 12'h010;
    localparam logic [11:0] FSTP_CLAMP_OFS   = 12'h014;
    localparam logic [11:0] FSTP_POST_OFS    = 12'h018;
    localparam logic [11:0] FSTP_STATUS_OFS  = 12'h01C;
    // Field positions
    localparam int FSTP_SIGN_POS   = 15;
    localparam int FSTP_COARSE_POS = 12;
    localparam int FSTP_HI_POS     = 12;
    localparam int FSTP_PSIGN_POS  = 24;
    // Reset values: unity gain, ceiling at top, post-curve gain 0x7FF, everything else zero
    localparam logic [31:0] FSTP_GAIN_RST  = 32'h0000_0400;
    localparam logic [31:0] FSTP_CLAMP_RST = 32'h00FF_F000;
    localparam logic [31:0] FSTP_POST_RST  = 32'h0000_07FF;
    // Temperature reference, degrees C
    localparam logic signed [8:0] FSTP_TREF = 9'sd25;
    // Fine gain: code 1024 is unity, LSB 1/2048
    localparam int FSTP_FINE_SHIFT = 11;
    // Polynomial scaling: 1/100 and 1/1000 folded into a 2^-20 fraction
    localparam logic signed [31:0] FSTP_TC1_WARM_K = 32'sd1;
    localparam logic signed [31:0] FSTP_TC1_COOL_K = 32'sd2;
    localparam logic signed [31:0] FSTP_TC2_WARM_K = 32'sd1;
    localparam logic signed [31:0] FSTP_TC2_COOL_K = 32'sd4;
    localparam int FSTP_TC_SHIFT   = 18;
    localparam int FSTP_TC2_SHIFT  = 7;
    localparam int FSTP_OTC_SHIFT  = 6;
    typedef struct packed {
        logic               sign;
        logic [2:0]         coarse;
        logic [10:0]        fine;
    } fstp_gain_t;
    typedef struct packed {
        logic signed [16:0] gainOut;
        logic signed [12:0] ofsOut;
    } fstp_stage_t;
endpackage

// ### tb_field_signal_trim_path.sv
`timescale 1ns/1ps
`default_nettype none
module tb_field_signal_trim_path;
    import fstp_pkg::*;
    logic                sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, sampleValid = 0;
    logic [11:0]         paddr = '0;
    logic [31:0]         pwdata = '0, prdata, rd;
    logic                pready, pslverr, outValid, curveValid, er;
    logic signed [15:0]  sampleIn = '0;
    logic signed [8:0]   ambientTemp = 9'sd25;
    logic [11:0]         outCode;
    logic signed [12:0]  curveOut;
    logic                sg = 0, pin = 0, pout = 0;
    logic [2:0]          cc = 0;
    logic [10:0]         fc = 11'h400;
    logic signed [15:0]  trim = 0;
    logic signed [11:0]  ow = 0, oc = 0, poff = 0;
    logic [11:0]         flo = 0, cei = 12'hFFF;
    logic signed [10:0]  tw1 = 0, tc1c = 0;
    logic signed [9:0]   tw2 = 0, tc2c = 0;
    logic [24:0]         expQ[$];
    logic [31:0]         rstTab [8] = '{FSTP_GAIN_RST, 0, 0, 0, 0, FSTP_CLAMP_RST, FSTP_POST_RST, 0};
    int                  fails = 0, nTests = 0, cyc = 0, seed = 96;
    field_signal_trim_path field_signal_trim_path_inst (.sys_clk(sys_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sampleValid(sampleValid), .sampleIn(sampleIn), .ambientTemp(ambientTemp),
        .outValid(outValid), .outCode(outCode), .curveValid(curveValid), .curveOut(curveOut));
    always #20 sys_clk = ~sys_clk;
    task end_of_test;
        $display("compares %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chkReg(input string n, input logic [31:0] ex, input logic [31:0] got);
        nTests++;
        if (got !== ex)
        begin
            fails++;
            $display("[FAIL] %s exp %h got %h", n, ex, got);
        end
    endtask
    task chkSmp(input logic [25:0] ex, input logic [25:0] got);
        nTests++;
        if (got !== ex)
        begin
            fails++;
            $display("[FAIL] sample exp %h got %h", ex, got);
        end
    endtask
    // Setup, then hold the access until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rdChk(input logic [11:0] a, input logic [31:0] ex);
        apb(0, a, 0);
        chkReg("prdata", ex, rd);
        chkReg("pslverr", {31'h0, a > FSTP_STATUS_OFS}, {31'h0, er});
    endtask
    task wcfg;
        apb(1, FSTP_GAIN_OFS, {16'h0000, sg, cc, 1'b0, fc});
        apb(1, FSTP_TCGAIN1_OFS, {9'h000, tc1c, 1'b0, tw1});
        apb(1, FSTP_TCGAIN2_OFS, {10'h000, tc2c, 2'b00, tw2});
        apb(1, FSTP_OFFSET_OFS, {16'h0000, trim});
        apb(1, FSTP_TCOFS_OFS, {8'h00, oc, ow});
        apb(1, FSTP_CLAMP_OFS, {8'h00, cei, flo});
        apb(1, FSTP_POST_OFS, {6'h00, pout, pin, poff, 12'h800});
    endtask
    function automatic longint sat(input longint v, input longint m);
        return v > m ? m : (v < -m - 1 ? -m - 1 : v);
    endfunction
    // Reference: gain, sign, trim, offset drift, clamps, then post-curve path with gain of -1
    function automatic logic [24:0] model(input int x, input int t);
        longint y, v, c, p;
        int dt;
        dt = t - 25;
        y = longint'(x) <<< (cc > 5 ? 5 : cc);
        y = (y * (longint'(fc) + 1024)) >>> FSTP_FINE_SHIFT;
        // Temperature polynomial in 2^-20 units; one warm first-order LSB weighs 4
        p = dt >= 0 ? longint'(tw2) * FSTP_TC2_WARM_K : longint'(tc2c) * FSTP_TC2_COOL_K;
        p = ((p * dt) >>> FSTP_TC2_SHIFT) + (dt >= 0 ? tw1 * FSTP_TC1_WARM_K : tc1c * FSTP_TC1_COOL_K);
        p = (longint'(1) <<< 20) + p * dt * 4;
        y = (y * p) >>> 20;
        if (sg) y = -y;
        y = sat(y, 65535);
        y = sat(y + trim + ((dt >= 0 ? ow * dt : oc * 2 * dt) >>> FSTP_OTC_SHIFT), 4095);
        v = y + 2048;
        if (v < int'(flo)) v = flo;
        if (v > int'(cei)) v = cei;
        c = pin ? -y : y;
        if (pout) c = -c;
        c = sat(-c + poff, 4095);
        return {v[11:0], c[12:0]};
    endfunction
    task smp(input logic signed [15:0] x, input logic signed [8:0] t);
        @(posedge sys_clk);
        sampleValid <= 1;
        sampleIn <= x;
        ambientTemp <= t;
        expQ.push_back(model(x, t));
    endtask
    task idle(input string s);
        @(posedge sys_clk);
        sampleValid <= 0;
        repeat (6) @(posedge sys_clk);
        $display("test %s done", s);
    endtask
    always @(posedge sys_clk)
    begin
        if (!srst && outValid === 1'b1)
        begin
            if (expQ.size() == 0) chkReg("spare outValid", 0, 1);
            else chkSmp({1'b1, expQ.pop_front()}, {curveValid, outCode, curveOut});
        end
    end
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            chkReg("timeout", 0, 1);
            end_of_test;
        end
    end
    initial
    begin
        repeat (8) @(posedge sys_clk);
        srst <= 0;
        @(posedge sys_clk);
        chkReg("outValid", 0, {31'h0, outValid});
        apb(1, FSTP_STATUS_OFS, 32'hFFFF_FFFF);
        for (int i = 0; i < 9; i++) rdChk(12'(4 * i), i < 8 ? rstTab[i] : 32'h0);
        apb(1, 12'h020, 32'h1234_5678);
        chkReg("wr pslverr", 1, {31'h0, er});
        $display("test registers done");
        wcfg;
        for (int s = 0; s < 2; s++)
            for (int c = 0; c < 8; c++)
            begin
                {sg, cc} = {s[0], c[2:0]};
                wcfg;
                smp(-16'sd100, 25);
                smp(16'sd7, 25);
                idle("coarse");
            end
        {sg, cc} = 0;
        foreach (rstTab[k])
        begin
            fc = k[0] ? 11'h7FF : 11'h000;
            wcfg;
            smp(16'sd2048, 25);
            smp(-16'sd2048, 25);
            idle("fine");
        end
        {fc, ow, oc, trim} = {11'h400, 12'sd64, 12'sd128, -16'sd500};
        wcfg;
        for (int t = 15; t <= 35; t += 10) smp(0, 9'(t));
        idle("drift");
        {ow, oc, trim, flo, cei} = {12'sd0, 12'sd0, 16'sd0, 12'd100, 12'd3000};
        for (int k = 0; k < 2; k++)
        begin
            wcfg;
            smp(-16'sd3000, 25);
            smp(16'sd3000, 25);
            smp(0, 25);
            idle("clamp");
            {flo, cei} = {12'd3000, 12'd100};
        end
        {flo, cei, poff} = {12'd0, 12'hFFF, 12'sd5};
        for (int k = 0; k < 4; k++)
        begin
            {pin, pout} = k[1:0];
            wcfg;
            smp(16'sd300, 25);
            idle("curve sign");
        end
        {poff, tw1, tc1c, tw2, tc2c} = {12'sd0, 11'sd100, -11'sd100, 10'sd40, -10'sd20};
        wcfg;
        for (int t = -15; t <= 65; t += 40) smp(16'sd1000, 9'(t));
        idle("gain drift");
        for (int k = 0; k < 3; k++)
        begin
            {cc, trim} = k == 0 ? {3'd0, -16'sd32768} : (k == 1 ? {3'd0, 16'sd32767} : {3'd7, 16'sd0});
            wcfg;
            smp(k == 2 ? -16'sd32768 : 16'sd0, 25);
            idle("saturate");
        end
        for (int r = 0; r < 20; r++)
        begin
            {sg, cc, pin, pout} = 6'($random(seed));
            trim = 16'($random(seed));
            poff = 12'($random(seed));
            wcfg;
            repeat (10) smp(16'($random(seed)), 9'(-40 + $unsigned($random(seed)) % 191));
            idle("random");
        end
        chkReg("queue", 0, expQ.size());
        end_of_test;
    end
endmodule // tb_field_signal_trim_path
`default_nettype wire
